// [core/otp_pkg.sv]
/*
 Shared constants, codes and types for the one-time programmable memory
 programming port: the device end and the programmer end.
 Assumes a 250 MHz pclk on both ends.
*/
package otp_pkg;
   // ----------------------------------------
   // Memory geometry
   // ----------------------------------------
   localparam int WORDS = 2026;
   localparam int WORD_W = 10;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 11;
   localparam int PRESC_W = 2;
   localparam logic [10:0] TEST_START = 11'h7EA;
   localparam logic [10:0] TEST_END = 11'h7FF;

   // ----------------------------------------
   // Mode pin codes, bit 0 is mode pin 0
   // ----------------------------------------
   localparam logic [3:0] MD_CLEAR = 4'h5;
   localparam logic [3:0] MD_WRITE = 4'hE;
   localparam logic [3:0] MD_VERIFY = 4'hC;
   localparam logic [3:0] MD_INHIBIT = 4'hD;
   localparam logic [3:0] MD_IDLE = 4'h0;

   typedef enum logic [2:0] {
      OTP_OTHER = 3'b000,
      OTP_CLEAR = 3'b001,
      OTP_WRITE = 3'b010,
      OTP_VERIFY = 3'b011,
      OTP_INHIBIT = 3'b100
   } otp_mode_t;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int CLK_PERIOD_NS = 4;
   localparam int T_VDD_WAIT_US = 10;
   localparam int VDD_WAIT_CYC = T_VDD_WAIT_US * CLK_MHZ;
   localparam int T_OSC_MS = 2;
   localparam int OSC_CYC = T_OSC_MS * 1000 * CLK_MHZ;
   localparam int T_PULSE_MS = 1;
   localparam int PULSE_CYC = T_PULSE_MS * 1000 * CLK_MHZ;
   localparam int LINK_PERIOD_NS = 160;
   localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int SETTLE_CYC = 8;
   localparam int RST_HOLD_CYC = 1024;
   localparam int RETRY_MAX = 25;

   // ----------------------------------------
   // Programmer registers (APB, byte offsets)
   // ----------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_WDATA = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_RDATA = 8'h0C;
   localparam logic [7:0] REG_ADDR = 8'h10;
   localparam logic [2:0] OP_ENTER = 3'h1;
   localparam logic [2:0] OP_PROG = 3'h2;
   localparam logic [2:0] OP_READ = 3'h3;
   localparam logic [2:0] OP_FINISH = 3'h4;
   localparam int ST_BUSY = 0;
   localparam int ST_POWERED = 1;
   localparam int ST_FAIL = 2;
   localparam int ST_REFUSED = 3;
   localparam int ST_TRIES = 8;

   typedef enum logic [3:0] {
      PS_IDLE = 4'b0000,
      PS_VDD = 4'b0001,
      PS_OSC = 4'b0010,
      PS_CLR = 4'b0011,
      PS_RAISE = 4'b0100,
      PS_INH = 4'b0101,
      PS_WR = 4'b0110,
      PS_INH2 = 4'b0111,
      PS_VFY = 4'b1000,
      PS_XTRA = 4'b1001,
      PS_INH3 = 4'b1010,
      PS_ADV = 4'b1011,
      PS_CLR_END = 4'b1100,
      PS_LOWER = 4'b1101,
      PS_OFF = 4'b1110
   } otp_pstate_t;

   function automatic otp_mode_t otp_decode(input logic [3:0] m);
      if (m == MD_CLEAR) begin
         return OTP_CLEAR;
      end else if (m == MD_WRITE) begin
         return OTP_WRITE;
      end else if (m == MD_VERIFY) begin
         return OTP_VERIFY;
      end else if (m[0] && m[2] && m[3]) begin
         return OTP_INHIBIT;
      end
      return OTP_OTHER;
   endfunction
endpackage

// [core/otp_if.sv]
/*
 Pins between the programmer and the device.
 The shared data bus is resolved here from both enables; undriven it
 reads as the pull-down level.
*/
`timescale 1ns/10ps
`default_nettype none
interface otp_if;
   logic [3:0] mode_select_pins;
   logic addr_clk;
   logic vdd_on;
   logic vdd_high;
   logic vpp_on;
   logic vpp_high;
   logic [7:0] pgm_data_out;
   logic pgm_data_oe_n;
   logic [7:0] dev_data_out;
   logic dev_data_oe_n;
   logic [7:0] prog_data_bus;

   assign prog_data_bus = !pgm_data_oe_n ? pgm_data_out :
                          (!dev_data_oe_n ? dev_data_out : 8'h00);

   modport programmer (
      output mode_select_pins, addr_clk, vdd_on, vdd_high, vpp_on, vpp_high,
      output pgm_data_out, pgm_data_oe_n,
      input prog_data_bus
   );
   modport device (
      input mode_select_pins, addr_clk, vdd_on, vdd_high, vpp_on, vpp_high,
      input prog_data_bus,
      output dev_data_out, dev_data_oe_n
   );
endinterface
`default_nettype wire

// [core/otp_sync.sv]
/*
 Two-flop synchroniser for a vector of independent levels.
 Assumes each bit is sampled on its own; no word coherence.
*/
`timescale 1ns/10ps
`default_nettype none
module otp_sync #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule
`default_nettype wire

// [core/otp_device.sv]
/*
 Device end: programming and verify port of the one-time memory.
 Assumes the programmer keeps its own sequencing; all pins arrive
 asynchronously and are synchronised first.
*/
`timescale 1ns/10ps
`default_nettype none
module otp_device
   import otp_pkg::*;
#(
   parameter int PROG_MIN_CYC = otp_pkg::PULSE_CYC / 2,
   parameter int RST_HOLD = otp_pkg::RST_HOLD_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   otp_if.device link
);
   import otp_pkg::*;

   if (PROG_MIN_CYC < 1 || RST_HOLD < 1) begin : g_bad
      $error("otp_device: counts must be at least one");
   end

   logic [16:0] raw;
   logic [16:0] s;
   logic vdd_on, vdd_high, vpp_on, vpp_high, aclk, aclk_q, active;
   logic [3:0] mode;
   logic [7:0] din;
   logic [31:0] rst_cnt, wr_cnt;
   logic [ADDR_W-1:0] addr;
   logic [PRESC_W-1:0] presc;
   logic [WORD_W-1:0] mem [WORDS];
   otp_mode_t md;

   assign raw = {link.vdd_on, link.vdd_high, link.vpp_on, link.vpp_high,
                 link.addr_clk, link.mode_select_pins, link.prog_data_bus};

   otp_sync #(.W(17)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(raw),
      .q(s)
   );

   assign {vdd_on, vdd_high, vpp_on, vpp_high, aclk, mode, din} = s;
   assign md = active ? otp_decode(mode) : OTP_OTHER; // RL4

   // ----------------------------------------
   // Entry from reset status
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_cnt <= 0;
      end else if (!vdd_on || active) begin
         rst_cnt <= 0;
      end else if (!vdd_high && !vpp_on && !vpp_high && rst_cnt != RST_HOLD) begin
         rst_cnt <= rst_cnt + 1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active <= 1'b0;
      end else if (!vdd_on || !vdd_high || !vpp_on || !vpp_high) begin
         active <= 1'b0;
      end else if (rst_cnt == RST_HOLD) begin
         active <= 1'b1; // RL3
      end
   end

   // ----------------------------------------
   // Address counter, advanced by address clock
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aclk_q <= 1'b0;
      end else begin
         aclk_q <= aclk;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr <= '0;
         presc <= '0;
      end else if (md == OTP_CLEAR) begin
         addr <= '0; // RL16
         presc <= '0; // RL16
      end else if (active && aclk && !aclk_q) begin
         presc <= presc + 1'b1;
         if (presc == 2'h3) begin
            addr <= addr + 1'b1; // RL2
         end
      end
   end

   // ----------------------------------------
   // Write: burns once per held write pulse
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_cnt <= 0;
      end else if (md != OTP_WRITE) begin
         wr_cnt <= 0;
      end else if (wr_cnt != PROG_MIN_CYC) begin
         wr_cnt <= wr_cnt + 1;
      end
   end

   // Erased cells read zero; programming can only set bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < WORDS; i++) begin
            mem[i] <= '0;
         end
      end else if (md == OTP_WRITE && wr_cnt == PROG_MIN_CYC - 1 &&
                   int'(addr) < WORDS) begin
         mem[addr] <= mem[addr] | {2'b00, din}; // RL1 RL5
      end
   end

   // ----------------------------------------
   // Verify: drive the bus with the current word
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.dev_data_out <= 8'h00;
         link.dev_data_oe_n <= 1'b1;
      end else begin
         link.dev_data_oe_n <= (md != OTP_VERIFY); // RL5
         if (int'(addr) < WORDS) begin
            link.dev_data_out <= mem[addr][7:0]; // RL14
         end else begin
            link.dev_data_out <= 8'h00;
         end
      end
   end
endmodule
`default_nettype wire

// [core/otp_programmer.sv]
/*
 Programmer end: drives supplies, mode pins, address clock and data
 for the one-time memory, ordered by software over APB.
 Assumes an APB master on pclk and the device on the far side of otp_if.
*/
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Operation
// [RL1] Memory holds 2026 ten-bit words
// [RL2] Four address clock pulses advance address
// [RL3] Enter mode from reset via raised supplies
// [RL4] Mode pins select clear, write, verify, inhibit
// [RL5] Programmer drives data on write, device on verify
// [RL6] Clock, Vpp low; wait 10 us
// [RL7] Wait 2 ms before any mode
// [RL8] Clear, raise supplies, then inhibit
// [RL9] Hold write 1 ms per location
// [RL10] Inhibit, verify, retry until data match
// [RL11] Extra write of tries times 1 ms
// [RL12] Inhibit then four pulses to advance
// [RL13] Finish: clear, normal supplies, power off
// [RL14] Verify reads successive words per four pulses
// [RL15] Never program the test area
// [RL16] Clear mode zeroes counter and prescaler
module otp_programmer
   import otp_pkg::*;
#(
   parameter int OSC_WAIT_CYC = otp_pkg::OSC_CYC,
   parameter int PULSE_WIDTH_CYC = otp_pkg::PULSE_CYC,
   parameter int MAX_TRIES = otp_pkg::RETRY_MAX
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   otp_if.programmer link
);
   import otp_pkg::*;
   if (OSC_WAIT_CYC < 1 || PULSE_WIDTH_CYC < 1 ||
       MAX_TRIES < 1 || MAX_TRIES > 255) begin : g_bad
      $error("otp_programmer: parameter out of range");
   end

   otp_pstate_t state, next_state;
   logic [31:0] tmr;
   logic [4:0] hc;
   logic [2:0] op;
   logic [7:0] wdata, rdata, tries, xleft, din;
   logic [ADDR_W-1:0] addr;
   logic powered, fail, refused, done, start, cmd_ok, wr_acc, mapped, match;

   otp_sync #(.W(8)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(link.prog_data_bus),
      .q(din)
   );

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   assign pready = 1'b1;
   assign mapped = paddr == REG_CTRL || paddr == REG_WDATA || paddr == REG_STATUS ||
                   paddr == REG_RDATA || paddr == REG_ADDR;
   assign pslverr = psel && penable && !mapped;
   assign wr_acc = psel && penable && pwrite;
   assign start = wr_acc && paddr == REG_CTRL && state == PS_IDLE && cmd_ok;
   assign match = din == wdata;

   always_comb begin
      cmd_ok = 1'b0;
      case (pwdata[2:0])
         OP_ENTER: cmd_ok = !powered;
         OP_PROG: cmd_ok = powered && addr < TEST_START; // RL15
         OP_READ: cmd_ok = powered;
         OP_FINISH: cmd_ok = powered;
         default: cmd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable) begin
         case (paddr)
            REG_WDATA: prdata <= {24'h000000, wdata};
            REG_STATUS: prdata <= {16'h0000, tries, 4'h0, refused, fail, powered,
                                   state != PS_IDLE};
            REG_RDATA: prdata <= {24'h000000, rdata};
            REG_ADDR: prdata <= {21'h000000, addr};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdata <= 8'h00;
      end else if (wr_acc && paddr == REG_WDATA) begin
         wdata <= pwdata[7:0];
      end
   end
   // A start write clears the sticky flags; they are set only later
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {op, refused} <= 4'h0;
      end else if (start) begin
         op <= pwdata[2:0];
         refused <= 1'b0;
      end else if (wr_acc && paddr == REG_CTRL) begin
         refused <= 1'b1;
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   assign done = tmr == 0;
   function automatic int dur(input otp_pstate_t st);
      case (st)
         PS_VDD: return VDD_WAIT_CYC;
         PS_OSC: return OSC_WAIT_CYC;
         PS_WR, PS_XTRA: return PULSE_WIDTH_CYC;
         PS_ADV: return 8 * LINK_HALF_CYC;
         PS_IDLE, PS_OFF: return 1;
         default: return SETTLE_CYC;
      endcase
   endfunction
   always_comb begin
      next_state = state;
      case (state)
         PS_IDLE: begin
            if (start) begin
               case (pwdata[2:0])
                  OP_ENTER: next_state = PS_VDD;
                  OP_PROG: next_state = PS_WR;
                  OP_READ: next_state = PS_VFY;
                  default: next_state = PS_CLR_END;
               endcase
            end
         end
         PS_VDD: if (done) next_state = PS_OSC; // RL6
         PS_OSC: if (done) next_state = PS_CLR; // RL7
         PS_CLR: if (done) next_state = PS_RAISE; // RL8
         PS_RAISE: if (done) next_state = PS_INH; // RL8
         PS_INH: if (done) next_state = PS_IDLE;
         PS_WR: if (done) next_state = PS_INH2; // RL9
         PS_INH2: if (done) next_state = PS_VFY; // RL10
         PS_VFY: begin
            if (done) begin
               if (op == OP_READ) begin
                  next_state = PS_ADV; // RL14
               end else if (match) begin
                  next_state = PS_XTRA; // RL11
               end else if (int'(tries) < MAX_TRIES) begin
                  next_state = PS_WR; // RL10
               end else begin
                  next_state = PS_INH3;
               end
            end
         end
         PS_XTRA: if (done && xleft == 8'h01) next_state = PS_INH3; // RL11
         PS_INH3: if (done) next_state = fail ? PS_IDLE : PS_ADV; // RL12
         PS_ADV: if (done) next_state = PS_IDLE;
         PS_CLR_END: if (done) next_state = PS_LOWER; // RL13
         PS_LOWER: if (done) next_state = PS_OFF; // RL13
         PS_OFF: next_state = PS_IDLE;
         default: next_state = PS_IDLE;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= PS_IDLE;
         tmr <= 0;
      end else begin
         state <= next_state;
         if (next_state != state || (state == PS_XTRA && done)) begin
            tmr <= dur(next_state) - 1;
         end else if (!done) begin
            tmr <= tmr - 1;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {tries, xleft, fail, rdata} <= 25'h0000000;
      end else begin
         if (start) begin
            tries <= (pwdata[2:0] == OP_PROG) ? 8'h01 : 8'h00;
            fail <= 1'b0;
         end else if (state == PS_VFY && next_state == PS_WR) begin
            tries <= tries + 8'h01;
         end else if (state == PS_VFY && next_state == PS_INH3) begin
            fail <= 1'b1;
         end
         if (state == PS_VFY && done) begin
            rdata <= din;
         end
         if (state == PS_VFY && next_state == PS_XTRA) begin
            xleft <= tries; // RL11
         end else if (state == PS_XTRA && done) begin
            xleft <= xleft - 8'h01;
         end
      end
   end

   // ----------------------------------------
   // Address clock divider and shadow address
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {hc, link.addr_clk} <= 6'h00;
      end else if (state != PS_ADV) begin
         {hc, link.addr_clk} <= 6'h00; // RL6
      end else if (int'(hc) == LINK_HALF_CYC - 1) begin
         hc <= 5'h00;
         link.addr_clk <= !link.addr_clk; // RL12
      end else begin
         hc <= hc + 5'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr <= '0;
      end else if (state == PS_CLR || state == PS_CLR_END) begin
         addr <= '0;
      end else if (state == PS_ADV && done) begin
         addr <= addr + 1'b1; // RL12
      end
   end

   // ----------------------------------------
   // Supplies, mode pins and data drive
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {powered, link.vdd_on, link.vpp_on, link.vdd_high, link.vpp_high} <= 5'h00;
      end else begin
         case (next_state)
            PS_VDD: link.vdd_on <= 1'b1; // RL6
            PS_OSC: link.vpp_on <= 1'b1; // RL6
            PS_RAISE: {link.vdd_high, link.vpp_high, powered} <= 3'h7; // RL8
            PS_LOWER: {link.vdd_high, link.vpp_high} <= 2'h0; // RL13
            PS_OFF: {link.vdd_on, link.vpp_on, powered} <= 3'h0; // RL13
            default: powered <= powered;
         endcase
      end
   end
   // Mode pins held through idle and advance so a read keeps verifying
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {link.mode_select_pins, link.pgm_data_oe_n, link.pgm_data_out} <= {MD_IDLE, 9'h100};
      end else begin
         link.pgm_data_out <= wdata;
         link.pgm_data_oe_n <= !(next_state == PS_WR || next_state == PS_XTRA); // RL5
         case (next_state)
            PS_VDD, PS_OSC, PS_OFF: link.mode_select_pins <= MD_IDLE; // RL7
            PS_CLR, PS_RAISE, PS_CLR_END, PS_LOWER: link.mode_select_pins <= MD_CLEAR;
            PS_INH, PS_INH2, PS_INH3: link.mode_select_pins <= MD_INHIBIT; // RL4
            PS_WR, PS_XTRA: link.mode_select_pins <= MD_WRITE; // RL9
            PS_VFY: link.mode_select_pins <= MD_VERIFY; // RL10
            default: link.mode_select_pins <= link.mode_select_pins;
         endcase
      end
   end
endmodule
`default_nettype wire

// [verif/otp_props.sv]
/*
 Checker on the pins between the programmer and the device.
 Assumes one pclk domain and one presetn shared by both ends.
*/
`timescale 1ns/10ps
`default_nettype none
module otp_props
   import otp_pkg::*;
#(
   parameter int PULSE_WIDTH_CYC = otp_pkg::PULSE_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] mode_select_pins,
   input wire logic addr_clk,
   input wire logic vdd_on,
   input wire logic vdd_high,
   input wire logic vpp_on,
   input wire logic vpp_high,
   input wire logic pgm_data_oe_n,
   input wire logic dev_data_oe_n
);
   logic [31:0] wait_cnt;
   logic [31:0] wr_cnt;
   logic [1:0] pulse_cnt;
   logic is_vfy;

   assign is_vfy = mode_select_pins == MD_VERIFY;

   // ----------------------------------------
   // Run lengths and pulse count
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) wait_cnt <= '0;
      else wait_cnt <= (vdd_on && !vpp_on) ? wait_cnt + 32'h1 : '0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) wr_cnt <= '0;
      else wr_cnt <= !pgm_data_oe_n ? wr_cnt + 32'h1 : '0;
   end

   // Two bits wrap, so a whole group of four reads back as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pulse_cnt <= '0;
      else if (mode_select_pins == MD_CLEAR) pulse_cnt <= '0;
      else if ($rose(addr_clk)) pulse_cnt <= pulse_cnt + 2'h1;
   end

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_vpp_wait;
      $rose(vpp_on) |-> wait_cnt >= 32'(VDD_WAIT_CYC) && !addr_clk;
   endproperty
   a_vpp_wait: assert property (p_vpp_wait) else $error("Vpp raised too early");
   property p_clear_first;
      $rose(vdd_high) |-> mode_select_pins == MD_CLEAR && vpp_high;
   endproperty
   a_clear_first: assert property (p_clear_first) else $error("raise not in clear");
   property p_lower_clear;
      $fell(vdd_high) |-> mode_select_pins == MD_CLEAR && !vpp_high;
   endproperty
   a_lower_clear: assert property (p_lower_clear) else $error("lower not in clear");
   property p_adv_mode;
      $rose(addr_clk) |-> mode_select_pins == MD_INHIBIT || is_vfy;
   endproperty
   a_adv_mode: assert property (p_adv_mode) else $error("clock pulse in bad mode");
   property p_groups;
      $changed(mode_select_pins) && mode_select_pins == MD_WRITE |-> pulse_cnt == 2'h0;
   endproperty
   a_groups: assert property (p_groups) else $error("partial pulse group");
   property p_pgm_drive;
      $fell(pgm_data_oe_n) |-> mode_select_pins == MD_WRITE && vpp_high;
   endproperty
   a_pgm_drive: assert property (p_pgm_drive) else $error("data driven outside write");
   property p_pulse_len;
      $rose(pgm_data_oe_n) |-> wr_cnt != 0 && wr_cnt % PULSE_WIDTH_CYC == 0;
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("write pulse length");
   property p_dev_drive;
      $rose(is_vfy) |-> ##[2:5] !dev_data_oe_n;
   endproperty
   a_dev_drive: assert property (p_dev_drive) else $error("device silent in verify");

   c_retry: cover property (is_vfy ##1 mode_select_pins == MD_WRITE);
   c_read: cover property (is_vfy && $rose(addr_clk));
   c_off: cover property ($fell(vdd_on));
endmodule
`default_nettype wire

// [verif/test_otp_program_verify_port.sv]
/*
 Self-checking bench: programmer and device joined by otp_if, ordered over APB.
 Assumes shortened oscillator wait and pulse width; whole run under 60000 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
   $display("wrong value at %0t: %s got %0h expected %0h", $time, m, g, e); end end
module test_otp_program_verify_port;
   import otp_pkg::*;
   localparam int PULSE = 40;
   localparam int TRIES = 25;
   localparam int LIMIT = 60000;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [31:0] rd;
   logic err;
   logic [7:0] exp_rd [3] = '{8'hA5, 8'h3C, 8'h00};
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;

   otp_if u_otp_if();
   otp_programmer #(.OSC_WAIT_CYC(50), .PULSE_WIDTH_CYC(PULSE), .MAX_TRIES(TRIES))
      u_otp_programmer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(u_otp_if.programmer));
   otp_device #(.PROG_MIN_CYC(20), .RST_HOLD(16)) u_otp_device (.pclk(pclk),
      .presetn(presetn), .link(u_otp_if.device));
   otp_props #(.PULSE_WIDTH_CYC(PULSE)) u_otp_props (.pclk(pclk), .presetn(presetn),
      .mode_select_pins(u_otp_if.mode_select_pins), .addr_clk(u_otp_if.addr_clk),
      .vdd_on(u_otp_if.vdd_on), .vdd_high(u_otp_if.vdd_high), .vpp_on(u_otp_if.vpp_on),
      .vpp_high(u_otp_if.vpp_high), .pgm_data_oe_n(u_otp_if.pgm_data_oe_n),
      .dev_data_oe_n(u_otp_if.dev_data_oe_n));

   always #2 pclk = ~pclk;

   // Hang guard
   always @(posedge pclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         bad_count++;
         stop_test();
      end
   end

   task stop_test;
      if (bad_count == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ----------------------------------------
   // APB master, entered just after a rising edge
   // ----------------------------------------
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Leaves the final status word in rd
   task run_op(input logic [2:0] op);
      apb(1'b1, REG_CTRL, {29'h0, op});
      apb(1'b0, REG_STATUS, 32'h0);
      while (rd[ST_BUSY] !== 1'b0) apb(1'b0, REG_STATUS, 32'h0);
   endtask

   task prog(input logic [7:0] v);
      apb(1'b1, REG_WDATA, {24'h0, v});
      run_op(OP_PROG);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, REG_STATUS, 32'h0);
      `CHK(rd, 32'h0, "reset status")
      apb(1'b0, 8'h14, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0}, "unmapped read")
      prog(8'hA5);
      `CHK(rd[3:0], 4'h8, "program while unpowered")
      run_op(OP_ENTER);
      `CHK(rd[3:0], 4'h2, "enter")
      run_op(OP_ENTER);
      `CHK(rd[3:0], 4'hA, "second enter")
      prog(8'hA5);
      `CHK(rd[15:0], 16'h0102, "program word 0")
      apb(1'b0, REG_ADDR, 32'h0);
      `CHK(rd[10:0], 11'h001, "address after word 0")
      prog(8'h3C);
      `CHK(rd[15:0], 16'h0102, "program word 1")
      run_op(OP_FINISH);
      `CHK(rd[1:0], 2'b00, "finish")
      // Fresh entry must restart reading at word 0
      run_op(OP_ENTER);
      for (int i = 0; i < 3; i++) begin
         run_op(OP_READ);
         apb(1'b0, REG_RDATA, 32'h0);
         `CHK(rd[7:0], exp_rd[i], "read back")
      end
      apb(1'b0, REG_ADDR, 32'h0);
      `CHK(rd[10:0], 11'h003, "address after reads")
      run_op(OP_FINISH);
      run_op(OP_ENTER);
      // Bits only set, so this word can never match
      prog(8'h5A);
      `CHK(rd[15:0], {8'(TRIES), 8'h06}, "retry to failure")
      apb(1'b0, REG_RDATA, 32'h0);
      `CHK(rd[7:0], 8'hFF, "merged word")
      apb(1'b0, REG_ADDR, 32'h0);
      `CHK(rd[10:0], 11'h000, "no advance on failure")
      run_op(OP_FINISH);
      `CHK(rd[1:0], 2'b00, "final power off")
      stop_test();
   end
endmodule
`default_nettype wire
